// ### pkg/rcs_regs.vh
/*
 Register offsets, field codes, reset values and timing constants for the
 receive output clock selector. Assumes a 32-bit AXI4-Lite register bus.
*/
`ifndef RCS_REGS_VH
`define RCS_REGS_VH

`define RCS_ADDR_W 6
`define RCS_OFS_CLKSEL 6'h00
`define RCS_OFS_STN 6'h04
`define RCS_OFS_INSERT 6'h08
`define RCS_OFS_CHSEL 6'h0C
`define RCS_OFS_BUFSZ 6'h10
`define RCS_OFS_STATUS 6'h14
`define RCS_OFS_MONLIM 6'h18

`define RCS_RESP_OKAY 2'h0
`define RCS_RESP_SLVERR 2'h2

`define RCS_SRC_SAT 3'h1
`define RCS_SRC_TX 3'h2
`define RCS_SRC_INT 3'h3
`define RCS_SRC_STN 3'h4
`define RCS_SRC_DCE 3'h5

`define RCS_LB_SAT 3'h1
`define RCS_LB_INT 3'h2
`define RCS_LB_STN 3'h3

`define RCS_CONN_NONE 2'h1
`define RCS_CONN_BNC 2'h2
`define RCS_CONN_RS422 2'h3

`define RCS_MODE_NORMAL 2'h0
`define RCS_MODE_GEN 2'h1
`define RCS_MODE_LOOP 2'h2

`define RCS_OUT_SAT 3'h0
`define RCS_OUT_TX 3'h1
`define RCS_OUT_INT 3'h2
`define RCS_OUT_STN 3'h3
`define RCS_OUT_DCE 3'h4
`define RCS_OUT_PLL 3'h5

`define RCS_F10M_KHZ 14'h2710
`define RCS_NMIN 6'h02
`define RCS_NMAX 6'h20
`define RCS_MONLIM_RST 16'h0040
`define RCS_BUFSZ_RST 7'h10

`endif

// ### rtl/rcs_clock_select.v
/*
 Receive output clock source selection and failover, with station clock
 setup, synthesiser reference substitution and partial insert channel select.
 Assumes clock sources arrive as slow pins sampled on aclk and registers
 are reached over AXI4-Lite.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rcs_regs.vh"

// What this block does
// - Satellite channels numbered by carrier order only
// - Station frequency in kHz, zero means absent
// - Station connection 1 none, 2 BNC, 3 RS422
// - Equal-rate transmit and DCE backups come from station clock when present
// - 10 MHz station may reference IF synthesisers
// - Failed external reference replaced by internal one
// - Plain output source codes one to five
// - Generated bearer source codes one to five, DCE only via backup
// - Looped bearer backup codes satellite, internal, station
// - Backup bearer clock only on looped failure
// - Satellite clock forces buffer size zero in normal insert mode
// - Satellite PLL falls to internal without lock
// - Equal-rate transmit clock direct, ordered backups
// - Asymmetric transmit clock via PLL, internal backup
// - Internal mode uses the internal reference
// - Equal station clock direct, satellite then internal
// - Unequal station clock via PLL, internal backup
// - Station with station-referenced transmit uses PLL
// - DCE clock direct, then live station, satellite only if no station, internal
// - Buffer size writable unless satellite in normal insert mode
// - Looped bearer loss or alarm switches to generation
module rcs_clock_select #(
	parameter NSRC = 5,
	parameter NCH = 32
) (
	input wire aclk,
	input wire aresetn,
	input wire [5:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [5:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire sat_clk,
	input wire tx_clk,
	input wire int_ref_clk,
	input wire stn_clk,
	input wire dce_clock_source,
	input wire pll_clk,
	input wire demod_lock,
	input wire rates_equal,
	input wire stn_equals_rx,
	input wire tx_ref_stn,
	input wire dte_card,
	input wire bearer_clk_loss,
	input wire alarm_indication_signal,
	input wire [NCH-1:0] sat_channel_in,
	output wire rx_clk_out,
	output wire [2:0] pll_ref_sel,
	output wire synth_ref_ext,
	output wire bearer_generate,
	output wire [NCH-1:0] insert_channel_en,
	output wire [6:0] buffer_size
);

	// Clock pin index per source
	localparam S_SAT = 0;
	localparam S_TX = 1;
	localparam S_STN = 2;
	localparam S_DCE = 3;
	localparam S_PLL = 4;

	// Switch state machine, one-hot
	localparam ST_RUN = 3'b001;
	localparam ST_LOW = 3'b010;
	localparam ST_SWAP = 3'b100;

	// Bus registers
	reg aw_full_ff, w_full_ff, bvalid_ff, rvalid_ff;
	reg [5:0] awaddr_ff;
	reg [31:0] wdata_ff, rdata_ff;
	reg [1:0] bresp_ff, rresp_ff;
	// Configuration registers
	reg [2:0] src_code_ff;
	reg [1:0] ins_mode_ff;
	reg [1:0] stn_conn_ff;
	reg [13:0] stn_khz_ff;
	reg synth_opt_ff;
	reg partial_ff;
	reg [5:0] total_n_ff;
	reg [NCH-1:0] chsel_ff;
	reg [6:0] bufsz_ff;
	reg [15:0] mon_lim_ff;
	// Monitor and output registers
	reg [NSRC-1:0] s1_ff, s2_ff, s3_ff;
	reg [15:0] idle_cnt_ff [0:NSRC-1];
	reg [NSRC-1:0] alive_ff;
	reg [2:0] sel_ff, want_ff;
	reg [2:0] st_ff;
	reg clk_out_ff;
	reg [2:0] pll_ref_ff;
	reg synth_ext_ff;
	reg gen_ff;
	reg [NCH-1:0] ins_en_ff;
	reg [6:0] buf_out_ff;

	wire [NSRC-1:0] pins = {pll_clk, dce_clock_source, stn_clk, tx_clk, sat_clk};
	wire stn_present = (stn_conn_ff != `RCS_CONN_NONE) && (stn_khz_ff != 14'h0000);
	wire sat_ok = alive_ff[S_SAT] & demod_lock;
	wire wr_go = aw_full_ff & w_full_ff & ~bvalid_ff;
	wire rd_go = s_axi_arvalid & ~rvalid_ff;

	// Presence monitors: three-stage sampling, edge resets an idle counter
	genvar gi;
	generate
		for (gi = 0; gi < NSRC; gi = gi + 1) begin : g_mon
			always @(posedge aclk) begin
				if (!aresetn) begin
					s1_ff[gi] <= 1'b0;
					s2_ff[gi] <= 1'b0;
					s3_ff[gi] <= 1'b0;
					idle_cnt_ff[gi] <= 16'h0000;
					alive_ff[gi] <= 1'b0;
				end else begin
					s1_ff[gi] <= pins[gi];
					s2_ff[gi] <= s1_ff[gi];
					s3_ff[gi] <= s2_ff[gi];
					if (s2_ff[gi] != s3_ff[gi]) begin
						idle_cnt_ff[gi] <= 16'h0000;
						alive_ff[gi] <= 1'b1;
					end else if (idle_cnt_ff[gi] >= mon_lim_ff) begin
						alive_ff[gi] <= 1'b0;
					end else begin
						idle_cnt_ff[gi] <= idle_cnt_ff[gi] + 16'h0001;
					end
				end
			end
		end
	endgenerate

	// Backup PLL reference: station if present and alive, else locked satellite only if no station, else internal
	reg [2:0] nxt_backup;
	always @* begin
		if (stn_present && alive_ff[S_STN])
			nxt_backup = `RCS_OUT_STN;
		else if (!stn_present && sat_ok)
			nxt_backup = `RCS_OUT_SAT;
		else
			nxt_backup = `RCS_OUT_INT;
	end

	// Source choice: want is the output tap, ref is what the PLL locks to
	reg [2:0] nxt_want, nxt_ref;
	reg nxt_gen;
	always @* begin
		nxt_want = `RCS_OUT_PLL;
		nxt_ref = `RCS_OUT_INT;
		nxt_gen = 1'b0;
		if (ins_mode_ff == `RCS_MODE_LOOP) begin
			nxt_gen = bearer_clk_loss | alarm_indication_signal;
			case (src_code_ff)
				`RCS_LB_SAT: nxt_ref = sat_ok ? `RCS_OUT_SAT : `RCS_OUT_INT;
				`RCS_LB_STN: nxt_ref = alive_ff[S_STN] ? `RCS_OUT_STN : `RCS_OUT_INT;
				default: nxt_ref = `RCS_OUT_INT;
			endcase
		end else begin
			case (src_code_ff)
				`RCS_SRC_SAT: nxt_ref = sat_ok ? `RCS_OUT_SAT : `RCS_OUT_INT;
				`RCS_SRC_TX: begin
					if (rates_equal && alive_ff[S_TX])
						nxt_want = `RCS_OUT_TX;
					else if (rates_equal)
						nxt_ref = nxt_backup;
					else
						nxt_ref = alive_ff[S_TX] ? `RCS_OUT_TX : `RCS_OUT_INT;
				end
				`RCS_SRC_STN: begin
					if (stn_equals_rx && !tx_ref_stn && alive_ff[S_STN])
						nxt_want = `RCS_OUT_STN;
					else if (stn_equals_rx && !tx_ref_stn)
						nxt_ref = sat_ok ? `RCS_OUT_SAT : `RCS_OUT_INT;
					else
						nxt_ref = alive_ff[S_STN] ? `RCS_OUT_STN : `RCS_OUT_INT;
				end
				`RCS_SRC_DCE: begin
					if (dte_card && ins_mode_ff == `RCS_MODE_NORMAL && alive_ff[S_DCE])
						nxt_want = `RCS_OUT_DCE;
					else
						nxt_ref = nxt_backup;
				end
				default: nxt_ref = `RCS_OUT_INT;
			endcase
		end
	end

	// Selected tap's sampled level
	reg tap_sel, tap_want;
	always @* begin
		case (sel_ff)
			`RCS_OUT_TX: tap_sel = s3_ff[S_TX];
			`RCS_OUT_STN: tap_sel = s3_ff[S_STN];
			`RCS_OUT_DCE: tap_sel = s3_ff[S_DCE];
			default: tap_sel = s3_ff[S_PLL];
		endcase
		case (want_ff)
			`RCS_OUT_TX: tap_want = s3_ff[S_TX];
			`RCS_OUT_STN: tap_want = s3_ff[S_STN];
			`RCS_OUT_DCE: tap_want = s3_ff[S_DCE];
			default: tap_want = s3_ff[S_PLL];
		endcase
	end

	// Glitch-free switch: wait until old tap is low, then hold low until new tap is low
	always @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= ST_RUN;
			sel_ff <= `RCS_OUT_PLL;
			want_ff <= `RCS_OUT_PLL;
			clk_out_ff <= 1'b0;
		end else begin
			want_ff <= nxt_want;
			case (st_ff)
				ST_RUN: begin
					clk_out_ff <= tap_sel;
					if (want_ff != sel_ff && !tap_sel)
						st_ff <= ST_LOW;
				end
				ST_LOW: begin
					clk_out_ff <= 1'b0;
					if (!tap_want) begin
						sel_ff <= want_ff;
						st_ff <= ST_SWAP;
					end
				end
				ST_SWAP: begin
					clk_out_ff <= 1'b0;
					st_ff <= ST_RUN;
				end
				default: st_ff <= ST_RUN;
			endcase
		end
	end

	// Derived outputs
	integer k;
	always @(posedge aclk) begin
		if (!aresetn) begin
			pll_ref_ff <= `RCS_OUT_INT;
			synth_ext_ff <= 1'b0;
			gen_ff <= 1'b0;
			ins_en_ff <= {NCH{1'b0}};
			buf_out_ff <= 7'h00;
		end else begin
			pll_ref_ff <= nxt_ref;
			// Degraded but toggling reference stays in use
			synth_ext_ff <= synth_opt_ff && stn_present && stn_khz_ff == `RCS_F10M_KHZ
				&& alive_ff[S_STN];
			gen_ff <= (ins_mode_ff == `RCS_MODE_GEN) | nxt_gen;
			for (k = 0; k < NCH; k = k + 1)
				ins_en_ff[k] <= sat_channel_in[k] & (partial_ff ? (chsel_ff[k] & (k < total_n_ff)) : 1'b1);
			buf_out_ff <= (src_code_ff == `RCS_SRC_SAT && ins_mode_ff == `RCS_MODE_NORMAL) ? 7'h00 : bufsz_ff;
		end
	end

	// Write channel: address and data latched in either order
	wire wsat = (src_code_ff == `RCS_SRC_SAT) && (ins_mode_ff == `RCS_MODE_NORMAL);
	wire [5:0] wn = wdata_ff[13:8];
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_ff <= 1'b0;
			w_full_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= `RCS_RESP_OKAY;
			awaddr_ff <= 6'h00;
			wdata_ff <= 32'h00000000;
			src_code_ff <= `RCS_SRC_INT;
			ins_mode_ff <= `RCS_MODE_NORMAL;
			stn_conn_ff <= `RCS_CONN_NONE;
			stn_khz_ff <= 14'h0000;
			synth_opt_ff <= 1'b0;
			partial_ff <= 1'b0;
			total_n_ff <= `RCS_NMIN;
			chsel_ff <= {NCH{1'b0}};
			bufsz_ff <= `RCS_BUFSZ_RST;
			mon_lim_ff <= `RCS_MONLIM_RST;
		end else begin
			if (s_axi_awvalid && !aw_full_ff) begin
				aw_full_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_full_ff) begin
				w_full_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
			end
			if (bvalid_ff && s_axi_bready)
				bvalid_ff <= 1'b0;
			if (wr_go) begin
				aw_full_ff <= 1'b0;
				w_full_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= `RCS_RESP_OKAY;
				case (awaddr_ff)
					`RCS_OFS_CLKSEL: begin
						if (wdata_ff[2:0] >= `RCS_SRC_SAT && wdata_ff[2:0] <= `RCS_SRC_DCE) begin
							src_code_ff <= wdata_ff[2:0];
						end else
							bresp_ff <= `RCS_RESP_SLVERR;
					end
					`RCS_OFS_STN: begin
						if (wdata_ff[1:0] == 2'h0)
							bresp_ff <= `RCS_RESP_SLVERR;
						else begin
							stn_conn_ff <= wdata_ff[1:0];
							stn_khz_ff <= (wdata_ff[1:0] == `RCS_CONN_NONE) ? 14'h0000 : wdata_ff[29:16];
							synth_opt_ff <= wdata_ff[2];
						end
					end
					`RCS_OFS_INSERT: begin
						if (wdata_ff[0] && (wn < `RCS_NMIN || wn > `RCS_NMAX))
							bresp_ff <= `RCS_RESP_SLVERR;
						else begin
							partial_ff <= wdata_ff[0];
							total_n_ff <= wn;
							ins_mode_ff <= (wdata_ff[5:4] == 2'h3) ? `RCS_MODE_NORMAL : wdata_ff[5:4];
						end
					end
					`RCS_OFS_CHSEL: chsel_ff <= wdata_ff[NCH-1:0];
					`RCS_OFS_BUFSZ: begin
						if (wsat)
							bresp_ff <= `RCS_RESP_SLVERR;
						else
							bufsz_ff <= wdata_ff[6:0];
					end
					`RCS_OFS_MONLIM: mon_lim_ff <= wdata_ff[15:0];
					default: bresp_ff <= `RCS_RESP_SLVERR;
				endcase
			end
		end
	end

	// Read channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= `RCS_RESP_OKAY;
		end else begin
			if (rvalid_ff && s_axi_rready)
				rvalid_ff <= 1'b0;
			if (rd_go) begin
				rvalid_ff <= 1'b1;
				rresp_ff <= `RCS_RESP_OKAY;
				case (s_axi_araddr)
					`RCS_OFS_CLKSEL: rdata_ff <= {29'h0, src_code_ff};
					`RCS_OFS_STN: rdata_ff <= {2'h0, stn_khz_ff, 13'h0, synth_opt_ff, stn_conn_ff};
					`RCS_OFS_INSERT: rdata_ff <= {18'h0, total_n_ff, 2'h0, ins_mode_ff, 3'h0, partial_ff};
					`RCS_OFS_CHSEL: rdata_ff <= chsel_ff;
					`RCS_OFS_BUFSZ: rdata_ff <= {25'h0, buf_out_ff};
					`RCS_OFS_STATUS: rdata_ff <= {16'h0, 1'b0, sel_ff, pll_ref_ff, gen_ff,
						synth_ext_ff, stn_present, demod_lock & alive_ff[S_SAT], alive_ff};
					`RCS_OFS_MONLIM: rdata_ff <= {16'h0, mon_lim_ff};
					default: begin
						rdata_ff <= 32'h00000000;
						rresp_ff <= `RCS_RESP_SLVERR;
					end
				endcase
			end
		end
	end

	assign s_axi_awready = ~aw_full_ff;
	assign s_axi_wready = ~w_full_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = ~rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign rx_clk_out = clk_out_ff;
	assign pll_ref_sel = pll_ref_ff;
	assign synth_ref_ext = synth_ext_ff;
	assign bearer_generate = gen_ff;
	assign insert_channel_en = ins_en_ff;
	assign buffer_size = buf_out_ff;

endmodule // rcs_clock_select
`default_nettype wire

// ### testbench/rcs_clock_select_asserts.sv
/*
 Checker for the clock selector ports.
 Assumes the monitor limit stays at or below 64 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module rcs_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic tx_clk,
	input wire logic stn_clk,
	input wire logic demod_lock,
	input wire logic [2:0] pll_ref_sel,
	input wire logic synth_ref_ext,
	input wire logic bearer_generate,
	input wire logic [6:0] buffer_size
);
	logic tx_d_ff;
	logic stn_d_ff;
	logic [7:0] tx_idle_ff;
	logic [7:0] stn_idle_ff;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Cycles since the last edge of the tx and station clock pins
	always_ff @(posedge aclk) begin
		tx_d_ff <= tx_clk;
		stn_d_ff <= stn_clk;
		tx_idle_ff <= (!aresetn || tx_clk != tx_d_ff) ? 8'h00 : tx_idle_ff + {7'h00, ~&tx_idle_ff};
		stn_idle_ff <= (!aresetn || stn_clk != stn_d_ff) ? 8'h00 : stn_idle_ff + {7'h00, ~&stn_idle_ff};
	end
	bw_next_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write response late");
	rd_next_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data late");
	b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write response stuck");
	r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read data stuck");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read accepted while busy");
	unlock_ref_a: assert property (!demod_lock [*5] |-> pll_ref_sel != 3'h0) else $error("unlocked ref");
	tx_dead_a: assert property (tx_idle_ff > 8'h50 |-> pll_ref_sel != 3'h1) else $error("dead tx ref");
	stn_dead_a: assert property (stn_idle_ff > 8'h50 |-> pll_ref_sel != 3'h3 && !synth_ref_ext)
		else $error("dead station ref");
	cover property ($rose(synth_ref_ext));
	cover property ($rose(bearer_generate));
	cover property (buffer_size == 7'h00);
endmodule // rcs_chk
bind rcs_clock_select rcs_chk i_rcs_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.tx_clk, .stn_clk, .demod_lock, .pll_ref_sel, .synth_ref_ext, .bearer_generate, .buffer_size);
`default_nettype wire

// ### testbench/rcs_terr.sv
/*
 Terrestrial side model: sources Tx input and DCE clocks, counts output edges.
 Assumes aclk as timing base; a stopped clock stands low.
*/
`timescale 1ns/1ps
`default_nettype none
module rcs_terr (
	input wire logic aclk,
	input wire logic tx_on,
	input wire logic dce_on,
	input wire logic rx_clk_out,
	output logic tx_clk,
	output logic dce_clock_source,
	output logic [15:0] rx_edges
);
	logic [2:0] ph_ff = 3'h0;
	logic rx_d_ff = 1'b0;
	initial {tx_clk, dce_clock_source, rx_edges} = 18'h00000;
	always @(posedge aclk) begin
		ph_ff <= ph_ff + 3'h1;
		tx_clk <= tx_on & ph_ff[2];
		dce_clock_source <= dce_on & ph_ff[2];
		rx_d_ff <= rx_clk_out;
		if (rx_clk_out && !rx_d_ff) rx_edges <= rx_edges + 16'h0001;
	end
endmodule // rcs_terr
`default_nettype wire

// ### testbench/tb_top.sv
/*
 Testbench: register tasks over AXI4-Lite and clock failover sequences.
 Assumes the register header is on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rcs_regs.vh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
	$display("unexpected at %0t: got %h exp %h", $time, (a), (e)); end end
module tb_top;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [5:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, sat_channel_in, rdat;
	logic [3:0] s_axi_wstrb;
	logic [1:0] rrsp;
	logic sat_clk, stn_clk, pll_clk, int_ref_clk, sat_en, stn_en, tx_on, dce_on, demod_lock, rates_equal;
	logic stn_equals_rx, tx_ref_stn, dte_card, bearer_clk_loss, alarm_indication_signal;
	logic [2:0] ph;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_clk_out;
	wire synth_ref_ext, bearer_generate, tx_clk, dce_clock_source;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata, insert_channel_en;
	wire [2:0] pll_ref_sel;
	wire [6:0] buffer_size;
	wire [15:0] rx_edges;
	int error_cnt = 0, tests_run = 0, i;
	logic [2:0] tap [1:5] = '{`RCS_OUT_PLL, `RCS_OUT_TX, `RCS_OUT_PLL, `RCS_OUT_STN, `RCS_OUT_DCE};
	rcs_clock_select i_rcs_clock_select (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .sat_clk, .tx_clk, .int_ref_clk, .stn_clk, .dce_clock_source, .pll_clk, .demod_lock,
		.rates_equal, .stn_equals_rx, .tx_ref_stn, .dte_card, .bearer_clk_loss, .alarm_indication_signal,
		.sat_channel_in, .rx_clk_out, .pll_ref_sel, .synth_ref_ext, .bearer_generate, .insert_channel_en,
		.buffer_size);
	rcs_terr i_rcs_terr (.aclk, .tx_on, .dce_on, .rx_clk_out, .tx_clk, .dce_clock_source, .rx_edges);
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		ph <= ph + 3'h1;
		sat_clk <= sat_en & ph[2];
		stn_clk <= stn_en & ph[2];
		pll_clk <= ph[1];
		int_ref_clk <= ph[0];
	end
	task automatic conclude;
		$display("errors %0d comparisons %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		{s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 40);
		if (s_axi_bvalid !== 1'b1) begin
			error_cnt++;
			conclude;
		end
		`CHK(s_axi_bresp, er)
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [5:0] a);
		int n;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 40);
		if (s_axi_rvalid !== 1'b1) begin
			error_cnt++;
			conclude;
		end
		{rrsp, rdat} = {s_axi_rresp, s_axi_rdata};
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic chk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a);
		`CHK({rrsp, rdat & m}, {2'h0, e})
	endtask
	// Status view: tap in [14:12], PLL reference in [11:9]
	task automatic st(input logic [2:0] t, input logic [2:0] r);
		chk(`RCS_OFS_STATUS, 32'h7E00, {17'h0, t, r, 9'h0});
	endtask
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, ph, sat_clk, stn_clk, pll_clk, int_ref_clk, tx_ref_stn} = '0;
		{bearer_clk_loss, alarm_indication_signal, aresetn} = 3'h0;
		{sat_en, stn_en, tx_on, dce_on, demod_lock, rates_equal, stn_equals_rx, dte_card} = 8'hFF;
		s_axi_wstrb = 4'hF;
		sat_channel_in = 32'h0000000F;
		tick(4);
		aresetn <= 1'b1;
		`CHK(pll_ref_sel, 3'h2)
		chk(`RCS_OFS_CLKSEL, 32'h7, 32'h3);
		chk(`RCS_OFS_MONLIM, 32'hFFFF, 32'h40);
		`CHK(buffer_size, `RCS_BUFSZ_RST)
		wr(`RCS_OFS_MONLIM, 32'h8, 2'h0);
		rd(6'h1C);
		`CHK({rrsp, rdat}, {2'h2, 32'h0})
		wr(`RCS_OFS_STN, 32'h08000002, 2'h0);
		wr(`RCS_OFS_CLKSEL, 32'h6, 2'h2);
		for (i = 1; i <= 5; i++) begin
			wr(`RCS_OFS_CLKSEL, 32'(i), 2'h0);
			tick(24);
			chk(`RCS_OFS_STATUS, 32'h7000, {17'h0, tap[i], 12'h0});
			`CHK(buffer_size, (i == 1) ? 7'h00 : 7'h10)
		end
		wr(`RCS_OFS_CLKSEL, 32'h1, 2'h0);
		wr(`RCS_OFS_BUFSZ, 32'h5, 2'h2);
		`CHK(pll_ref_sel, 3'h0)
		demod_lock <= 1'b0;
		tick(24);
		`CHK(pll_ref_sel, 3'h2)
		demod_lock <= 1'b1;
		wr(`RCS_OFS_CLKSEL, 32'h2, 2'h0);
		tx_on <= 1'b0;
		tick(24);
		st(`RCS_OUT_PLL, 3'h3);
		wr(`RCS_OFS_STN, 32'h08000001, 2'h0);
		chk(`RCS_OFS_STN, 32'h3FFF0003, 32'h1);
		st(`RCS_OUT_PLL, 3'h0);
		{rates_equal, tx_on} <= 2'h1;
		tick(24);
		st(`RCS_OUT_PLL, 3'h1);
		tx_on <= 1'b0;
		tick(100);
		st(`RCS_OUT_PLL, 3'h2);
		{rates_equal, tx_on} <= 2'h3;
		wr(`RCS_OFS_STN, 32'h27100007, 2'h0);
		tick(24);
		`CHK(synth_ref_ext, 1'b1)
		wr(`RCS_OFS_CLKSEL, 32'h4, 2'h0);
		tx_ref_stn <= 1'b1;
		tick(24);
		st(`RCS_OUT_PLL, 3'h3);
		{tx_ref_stn, stn_equals_rx, stn_en} <= 3'h0;
		tick(100);
		st(`RCS_OUT_PLL, 3'h2);
		`CHK(synth_ref_ext, 1'b0)
		stn_en <= 1'b1;
		wr(`RCS_OFS_STN, 32'h0, 2'h2);
		wr(`RCS_OFS_CLKSEL, 32'h5, 2'h0);
		dce_on <= 1'b0;
		tick(24);
		st(`RCS_OUT_PLL, 3'h3);
		wr(`RCS_OFS_INSERT, 32'h2101, 2'h2);
		wr(`RCS_OFS_INSERT, 32'h0411, 2'h0);
		wr(`RCS_OFS_CHSEL, 32'h5, 2'h0);
		tick(4);
		`CHK(insert_channel_en, 32'h5)
		wr(`RCS_OFS_INSERT, 32'h0020, 2'h0);
		wr(`RCS_OFS_CLKSEL, 32'h2, 2'h0);
		chk(`RCS_OFS_CLKSEL, 32'h7, 32'h2);
		for (i = 1; i <= 2; i++) begin
			{bearer_clk_loss, alarm_indication_signal} <= 2'(i);
			tick(6);
			`CHK(bearer_generate, 1'b1)
			{bearer_clk_loss, alarm_indication_signal} <= 2'h0;
			tick(6);
			`CHK(bearer_generate, 1'b0)
		end
		wr(`RCS_OFS_CLKSEL, 32'h3, 2'h0);
		tick(4);
		st(`RCS_OUT_PLL, 3'h3);
		`CHK(rx_edges != 16'h0000, 1'b1)
		conclude;
	end
	initial begin
		tick(100000);
		error_cnt++;
		conclude;
	end
endmodule // tb_top
`default_nettype wire
